// ===== autr_pkg.sv
// Package for the asynchronous serial transceiver: register map, fields,
// reset values, timing counts, state codes and shared character functions.
// Assumes a 32-bit AXI4-Lite register bus and 16x line clocks.
package autr_pkg;

   localparam int REF_CLK_HZ = 100_000_000;
   localparam int MAX_BIT_RATE = 9600;
   localparam int OVERSAMPLE = 16;

   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_TXDATA = 4'h4;
   localparam logic [3:0] REG_RXDATA = 4'h8;
   localparam logic [3:0] REG_STATUS = 4'hc;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // CTRL fields
   localparam int CTRL_WLEN_LSB = 0;
   localparam int CTRL_PINH_BIT = 2;
   localparam int CTRL_PSENSE_BIT = 3;
   localparam int CTRL_STOP_BIT = 4;
   localparam logic [1:0] WLEN_RST = 2'h3;
   localparam logic PINH_RST = 1'b1;
   localparam logic PSENSE_RST = 1'b0;
   localparam logic STOP_RST = 1'b0;

   // STATUS fields
   localparam int ST_AVAIL = 0;
   localparam int ST_OVR = 1;
   localparam int ST_PE = 2;
   localparam int ST_FE = 3;
   localparam int ST_TXE = 4;
   localparam int ST_DONE = 5;
   localparam logic [5:0] STATUS_RST = 6'h30;

   // Line clock ticks, counted from zero
   localparam logic [4:0] BIT_LAST = 5'h0f;
   localparam logic [4:0] HALF_LAST = 5'h07;
   localparam logic [4:0] STOP1_LAST = 5'h0f;
   localparam logic [4:0] STOP15_LAST = 5'h17;
   localparam logic [4:0] STOP2_LAST = 5'h1f;

   typedef enum logic [2:0] {
      TX_IDLE = 3'b000,
      TX_START = 3'b001,
      TX_DATA = 3'b010,
      TX_PAR = 3'b011,
      TX_STOP = 3'b100
   } autr_tx_st_t;

   typedef enum logic [2:0] {
      RX_HUNT = 3'b000,
      RX_START = 3'b001,
      RX_DATA = 3'b010,
      RX_PAR = 3'b011,
      RX_STOP = 3'b100
   } autr_rx_st_t;

   // Index of the last data bit: 5 to 8 bits per character
   function automatic logic [2:0] wordLast(input logic [1:0] sel);
      return 3'(3'd4 + {1'b0, sel});
   endfunction

   // Parity bit to send; sense high selects even
   function automatic logic charParity(input logic [7:0] d, input logic [1:0] sel,
                                       input logic sense);
      logic [7:0] mask;
      mask = 8'hff >> (2'd3 - sel);
      return sense ? ^(d & mask) : ~^(d & mask);
   endfunction

   function automatic logic [4:0] stopLast(input logic stopSel, input logic [1:0] sel);
      if (!stopSel) begin
         return STOP1_LAST;
      end
      return (sel == 2'h0) ? STOP15_LAST : STOP2_LAST;
   endfunction

endpackage

// ===== autr_rx.sv
// Receive engine: start edge hunt, start bit check, centre sampling.
// Assumes rxClock and serialInLine synchronous to ref_clk, rxClock at 16x.
`timescale 1ns/100ps
module autr_rx import autr_pkg::*; (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic rxClock,
   input wire logic serialInLine,
   input wire logic [1:0] wordSel,
   input wire logic parInh,
   input wire logic parSense,
   output logic charValid,
   output logic [7:0] charData,
   output logic charParityErr,
   output logic charFrameErr
);

   typedef struct packed {
      autr_rx_st_t st;
      logic clkPrev;
      logic linePrev;
      logic [4:0] cnt;
      logic [2:0] bitIdx;
      logic [7:0] data;
      logic parBit;
      logic valid;
      logic [7:0] outData;
      logic outPe;
      logic outFe;
   } autr_rx_s_t;

   autr_rx_s_t s;
   autr_rx_s_t next_s;
   logic tick;
   logic bitEnd;

   always_comb begin
      next_s = s;
      tick = rxClock && !s.clkPrev;
      bitEnd = tick && (s.cnt == BIT_LAST);
      next_s.clkPrev = rxClock;
      next_s.linePrev = serialInLine;
      next_s.valid = 1'b0;
      if (tick) begin
         next_s.cnt = 5'(s.cnt + 5'd1);
      end
      unique case (s.st)
         RX_HUNT: begin
            if (s.linePrev && !serialInLine) begin
               next_s.st = RX_START;
               next_s.cnt = 5'h00;
            end
         end
         RX_START: begin
            if (serialInLine) begin
               next_s.st = RX_HUNT;
            end else if (tick && s.cnt == HALF_LAST) begin
               next_s.st = RX_DATA;
               next_s.cnt = 5'h00;
               next_s.bitIdx = 3'h0;
               next_s.data = 8'h00;
            end
         end
         RX_DATA: begin
            if (bitEnd) begin
               next_s.cnt = 5'h00;
               next_s.data[s.bitIdx] = serialInLine;
               if (s.bitIdx == wordLast(wordSel)) begin
                  next_s.st = parInh ? RX_STOP : RX_PAR;
               end else begin
                  next_s.bitIdx = 3'(s.bitIdx + 3'd1);
               end
            end
         end
         RX_PAR: begin
            if (bitEnd) begin
               next_s.cnt = 5'h00;
               next_s.parBit = serialInLine;
               next_s.st = RX_STOP;
            end
         end
         RX_STOP: begin
            if (bitEnd) begin
               next_s.st = RX_HUNT;
               next_s.valid = 1'b1;
               next_s.outData = s.data;
               next_s.outFe = !serialInLine;
               next_s.outPe = !parInh &&
                  (s.parBit != charParity(s.data, wordSel, parSense));
            end
         end
         default: next_s.st = RX_HUNT;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '0;
         s.linePrev <= 1'b1;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign charValid = s.valid;
   assign charData = s.outData;
   assign charParityErr = s.outPe;
   assign charFrameErr = s.outFe;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b || !ce);

   hunt_edge_a: assert property (s.st == RX_HUNT && s.linePrev && !serialInLine
      |=> s.st == RX_START && s.cnt == 5'h00) else $error("start edge missed");
   start_abort_a: assert property (s.st == RX_START && serialInLine
      |=> s.st == RX_HUNT) else $error("false start not abandoned");
   rx_stop_a: assert property (s.st == RX_STOP && bitEnd
      |=> charValid && s.st == RX_HUNT) else $error("character not delivered");
   false_start_c: cover property (s.st == RX_START ##1 s.st == RX_HUNT);
endmodule

// ===== autr_station.sv
// Remote serial station: frames characters onto serialInLine and
// decodes characters from serialOutLine. Assumes line clocks from ref_clk.
`timescale 1ns/100ps
module autr_station (
   input wire logic txClock,
   input wire logic rxClock,
   input wire logic serialOutLine,
   output logic serialInLine
);
   logic [7:0] gotData;
   logic gotPar;
   logic gotStop;

   initial serialInLine = 1'b1;

   // Sixteen receive ticks per bit, two stop bits
   task automatic send(input logic [7:0] d, input int n, input logic pe, input logic pb);
      serialInLine <= 1'b0;
      repeat (16) @(posedge rxClock);
      for (int i = 0; i < n; i++) begin
         serialInLine <= d[i];
         repeat (16) @(posedge rxClock);
      end
      if (pe) begin
         serialInLine <= pb;
         repeat (16) @(posedge rxClock);
      end
      serialInLine <= 1'b1;
      repeat (32) @(posedge rxClock);
   endtask

   // Low for a quarter bit only
   task automatic glitch;
      serialInLine <= 1'b0;
      repeat (4) @(posedge rxClock);
      serialInLine <= 1'b1;
      repeat (16) @(posedge rxClock);
   endtask

   // Samples each bit at its centre; a silent line reports a dead stop bit
   task automatic grab(input int n, input logic pe);
      gotData = 8'h00;
      gotStop = 1'b0;
      for (int t = 0; t < 2000 && serialOutLine !== 1'b0; t++) begin
         @(negedge serialOutLine or posedge txClock);
      end
      if (serialOutLine === 1'b0) begin
         repeat (8) @(negedge txClock);
         for (int i = 0; i < n; i++) begin
            repeat (16) @(negedge txClock);
            gotData[i] = serialOutLine;
         end
         if (pe) begin
            repeat (16) @(negedge txClock);
            gotPar = serialOutLine;
         end
         repeat (16) @(negedge txClock);
         gotStop = serialOutLine;
      end
   endtask
endmodule

// ===== autr_uart.sv
// Asynchronous serial transceiver with AXI4-Lite registers and tri-state pins.
// Assumes line clocks and serial input synchronous to ref_clk; ce freezes state.
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
module autr_uart import autr_pkg::*; #(
   parameter int ADDR_W = 6
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic txClock,
   input wire logic rxClock,
   input wire logic serialInLine,
   output logic serialOutLine,
   output logic txBufferEmpty,
   output logic txCharDone,
   output logic dataAvailableFlag,
   input wire logic readDataEnableN,
   input wire logic statusOutputEnableN,
   output logic [7:0] rxDataBits,
   output logic rxDataOe,
   output logic [5:0] statusBits,
   output logic statusOe
);

   if (ADDR_W < 5 || REF_CLK_HZ < 2 * OVERSAMPLE * MAX_BIT_RATE) begin : g_check
      $error("autr_uart: ADDR_W below 5 or reference clock too slow");
   end

   typedef struct packed {
      logic awReady;
      logic awHeld;
      logic [ADDR_W-1:0] awAddr;
      logic wReady;
      logic wHeld;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bValid;
      logic [1:0] bResp;
      logic arReady;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
      logic [1:0] wordSel;
      logic parInh;
      logic parSense;
      logic stopSel;
      autr_tx_st_t txState;
      logic txClkPrev;
      logic [4:0] txCnt;
      logic [2:0] txBit;
      logic [7:0] txShift;
      logic txPar;
      logic [7:0] hold;
      logic holdFull;
      logic txOut;
      logic txEmpty;
      logic txDone;
      logic dataAvail;
      logic overrun;
      logic parityErr;
      logic frameErr;
      logic [7:0] rxBuf;
      logic [7:0] rxDataBits;
      logic rxDataOe;
      logic [5:0] statusBits;
      logic statusOe;
   } autr_state_t;

   autr_state_t s;
   autr_state_t next_s;
   logic charValid;
   logic [7:0] charData;
   logic charParityErr;
   logic charFrameErr;
   logic txTick;
   logic bitEnd;
   logic startChar;
   logic loadNow;
   logic clearNow;
   logic ctrlNow;
   logic wrMapped;
   logic rdMapped;

   function automatic logic [5:0] packStatus(input autr_state_t x);
      logic [5:0] v;
      v = 6'h00;
      v[ST_AVAIL] = x.dataAvail;
      v[ST_OVR] = x.overrun;
      v[ST_PE] = x.parityErr;
      v[ST_FE] = x.frameErr;
      v[ST_TXE] = x.txEmpty;
      v[ST_DONE] = x.txDone;
      return v;
   endfunction

   function automatic logic [31:0] readMux(input autr_state_t x,
                                          input logic [ADDR_W-1:0] a);
      logic [31:0] r;
      r = 32'h0000_0000;
      unique case (a[3:0])
         REG_CTRL: begin
            r[CTRL_WLEN_LSB +: 2] = x.wordSel;
            r[CTRL_PINH_BIT] = x.parInh;
            r[CTRL_PSENSE_BIT] = x.parSense;
            r[CTRL_STOP_BIT] = x.stopSel;
         end
         REG_TXDATA: r[7:0] = x.hold;
         REG_RXDATA: r[7:0] = x.rxBuf;
         REG_STATUS: r[5:0] = packStatus(x);
         default: r = 32'h0000_0000;
      endcase
      return r;
   endfunction

   function automatic logic isMapped(input logic [ADDR_W-1:0] a);
      return (a >> 4) == '0 && a[1:0] == 2'h0;
   endfunction

   // Receive engine; full duplex with the transmitter below
   autr_rx u_rx (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .ce(ce),
      .rxClock(rxClock),
      .serialInLine(serialInLine),
      .wordSel(s.wordSel),
      .parInh(s.parInh),
      .parSense(s.parSense),
      .charValid(charValid),
      .charData(charData),
      .charParityErr(charParityErr),
      .charFrameErr(charFrameErr)
   );

   always_comb begin
      next_s = s;
      loadNow = 1'b0;
      clearNow = 1'b0;
      ctrlNow = 1'b0;
      startChar = 1'b0;
      wrMapped = 1'b0;
      rdMapped = isMapped(s_axi_araddr);

      // Write channels, taken in either order
      if (s.bValid && s_axi_bready) begin
         next_s.bValid = 1'b0;
      end
      if (s.awReady && s_axi_awvalid) begin
         next_s.awHeld = 1'b1;
         next_s.awAddr = s_axi_awaddr;
      end
      if (s.wReady && s_axi_wvalid) begin
         next_s.wHeld = 1'b1;
         next_s.wData = s_axi_wdata;
         next_s.wStrb = s_axi_wstrb;
      end
      if (next_s.awHeld && next_s.wHeld && !next_s.bValid) begin
         wrMapped = isMapped(next_s.awAddr);
         next_s.awHeld = 1'b0;
         next_s.wHeld = 1'b0;
         next_s.bValid = 1'b1;
         next_s.bResp = wrMapped ? RESP_OKAY : RESP_SLVERR;
         if (wrMapped && next_s.wStrb[0]) begin
            ctrlNow = next_s.awAddr[3:0] == REG_CTRL;
            loadNow = next_s.awAddr[3:0] == REG_TXDATA;
            clearNow = next_s.awAddr[3:0] == REG_STATUS && next_s.wData[ST_AVAIL];
         end
      end
      next_s.awReady = !next_s.awHeld && !next_s.bValid;
      next_s.wReady = !next_s.wHeld && !next_s.bValid;

      // Read channels
      if (s.rValid && s_axi_rready) begin
         next_s.rValid = 1'b0;
      end
      if (s.arReady && s_axi_arvalid) begin
         next_s.rValid = 1'b1;
         next_s.rData = rdMapped ? readMux(s, s_axi_araddr) : 32'h0000_0000;
         next_s.rResp = rdMapped ? RESP_OKAY : RESP_SLVERR;
      end
      next_s.arReady = !next_s.rValid;

      // Format latch
      if (ctrlNow) begin
         next_s.wordSel = next_s.wData[CTRL_WLEN_LSB +: 2];
         next_s.parInh = next_s.wData[CTRL_PINH_BIT];
         next_s.parSense = next_s.wData[CTRL_PSENSE_BIT];
         next_s.stopSel = next_s.wData[CTRL_STOP_BIT];
      end

      // Transmitter, stepping on falling edges of the 16x clock
      txTick = !txClock && s.txClkPrev;
      bitEnd = txTick && s.txCnt == BIT_LAST;
      next_s.txClkPrev = txClock;
      if (txTick) begin
         next_s.txCnt = 5'(s.txCnt + 5'd1);
      end
      unique case (s.txState)
         TX_IDLE: begin
            startChar = txTick && s.holdFull;
         end
         TX_START: begin
            if (bitEnd) begin
               next_s.txState = TX_DATA;
               next_s.txCnt = 5'h00;
               next_s.txBit = 3'h0;
               next_s.txOut = s.txShift[0];
            end
         end
         TX_DATA: begin
            if (bitEnd) begin
               next_s.txCnt = 5'h00;
               if (s.txBit == wordLast(s.wordSel)) begin
                  next_s.txState = s.parInh ? TX_STOP : TX_PAR;
                  next_s.txOut = s.parInh ? 1'b1 : s.txPar;
               end else begin
                  next_s.txBit = 3'(s.txBit + 3'd1);
                  next_s.txOut = s.txShift[next_s.txBit];
               end
            end
         end
         TX_PAR: begin
            if (bitEnd) begin
               next_s.txCnt = 5'h00;
               next_s.txState = TX_STOP;
               next_s.txOut = 1'b1;
            end
         end
         TX_STOP: begin
            if (txTick && s.txCnt == stopLast(s.stopSel, s.wordSel)) begin
               if (s.holdFull) begin
                  startChar = 1'b1;
               end else begin
                  next_s.txState = TX_IDLE;
                  next_s.txDone = 1'b1;
               end
            end
         end
         default: next_s.txState = TX_IDLE;
      endcase
      if (startChar) begin
         next_s.txShift = s.hold;
         next_s.txPar = charParity(s.hold, s.wordSel, s.parSense);
         next_s.holdFull = 1'b0;
         next_s.txState = TX_START;
         next_s.txCnt = 5'h00;
         next_s.txOut = 1'b0;
         next_s.txDone = 1'b0;
      end
      if (loadNow) begin
         next_s.hold = next_s.wData[7:0];
         next_s.holdFull = 1'b1;
      end
      next_s.txEmpty = !next_s.holdFull;

      // Receive buffer; a new character wins over a clear
      if (clearNow) begin
         next_s.dataAvail = 1'b0;
      end
      if (charValid) begin
         next_s.overrun = s.dataAvail && !clearNow;
         next_s.dataAvail = 1'b1;
         next_s.rxBuf = charData;
         next_s.parityErr = charParityErr;
         next_s.frameErr = charFrameErr;
      end

      // Pin copies with their enables
      next_s.rxDataOe = !readDataEnableN;
      next_s.statusOe = !statusOutputEnableN;
      next_s.rxDataBits = next_s.rxBuf;
      next_s.statusBits = packStatus(next_s);
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '0;
         s.awReady <= 1'b1;
         s.wReady <= 1'b1;
         s.arReady <= 1'b1;
         s.wordSel <= WLEN_RST;
         s.parInh <= PINH_RST;
         s.parSense <= PSENSE_RST;
         s.stopSel <= STOP_RST;
         s.txOut <= 1'b1;
         s.txEmpty <= 1'b1;
         s.txDone <= 1'b1;
         s.statusBits <= STATUS_RST;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign s_axi_awready = s.awReady;
   assign s_axi_wready = s.wReady;
   assign s_axi_bresp = s.bResp;
   assign s_axi_bvalid = s.bValid;
   assign s_axi_arready = s.arReady;
   assign s_axi_rdata = s.rData;
   assign s_axi_rresp = s.rResp;
   assign s_axi_rvalid = s.rValid;
   assign serialOutLine = s.txOut;
   assign txBufferEmpty = s.txEmpty;
   assign txCharDone = s.txDone;
   assign dataAvailableFlag = s.dataAvail;
   assign rxDataBits = s.rxDataBits;
   assign rxDataOe = s.rxDataOe;
   assign statusBits = s.statusBits;
   assign statusOe = s.statusOe;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b || !ce);

   idle_outputs_a: assert property (s.txState == TX_IDLE && !s.holdFull
      |-> s.txOut && s.txEmpty) else $error("idle transmitter outputs not high");
   start_bit_a: assert property (s.txState == TX_IDLE && s.holdFull && txTick
      |=> s.txState == TX_START && !s.txOut) else $error("start bit late");
   load_empty_a: assert property (loadNow |=> !s.txEmpty && s.holdFull)
      else $error("buffer empty flag not cleared on load");
   stop_high_a: assert property (s.txState == TX_STOP |-> s.txOut)
      else $error("stop bit not mark");
   char_done_a: assert property (s.txState == TX_STOP && !s.holdFull && txTick
      && s.txCnt == stopLast(s.stopSel, s.wordSel) |=> s.txDone && s.txState == TX_IDLE)
      else $error("end of character flag missing");
   parity_out_a: assert property (s.txState == TX_PAR |-> s.txOut == s.txPar)
      else $error("parity bit wrong on line");
   overrun_set_a: assert property (charValid && s.dataAvail && !clearNow
      |=> s.overrun && s.dataAvail ##1 s.statusBits[ST_OVR]) else $error("overrun missed");
   pin_enable_a: assert property (!readDataEnableN && statusOutputEnableN
      |=> s.rxDataOe && !s.statusOe) else $error("pin enables wrong");

   overrun_c: cover property (charValid && s.dataAvail);
   back_to_back_c: cover property (s.txState == TX_STOP && s.holdFull);
   parity_err_c: cover property (charValid && charParityErr);
   slverr_c: cover property (s.bValid && s.bResp == RESP_SLVERR);
endmodule

// ===== testbench.sv
// Bench for the serial transceiver: AXI4-Lite register tasks, a remote
// station on the line. Assumes AXI answers one cycle after each handshake.
`timescale 1ns/100ps
module testbench import autr_pkg::*; ;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic txClock = 1'b0;
   logic rxClock = 1'b0;
   logic [2:0] div = 3'h0;
   logic [5:0] awaddr = 6'h00;
   logic [5:0] araddr = 6'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b1;
   logic arvalid = 1'b0;
   logic rready = 1'b1;
   logic readDataEnableN = 1'b1;
   logic statusOutputEnableN = 1'b1;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rr;
   logic [31:0] rdata, rv;
   logic serialInLine, serialOutLine, txBufferEmpty, txCharDone;
   logic dataAvailableFlag, rxDataOe, statusOe;
   logic [7:0] rxDataBits;
   logic [5:0] statusBits;
   int num_errors = 0;
   int checks_done = 0;

   always #5 ref_clk = ~ref_clk;

   // Line clocks: 4 and 8 ref cycles per tick
   always @(posedge ref_clk) begin
      div <= div + 3'h1;
      txClock <= div[1];
      rxClock <= div[2];
   end

   autr_uart #(.ADDR_W(6)) autr_uart_inst (.ref_clk(ref_clk), .rst_b(rst_b), .ce(1'b1),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .txClock(txClock),
      .rxClock(rxClock), .serialInLine(serialInLine), .serialOutLine(serialOutLine),
      .txBufferEmpty(txBufferEmpty), .txCharDone(txCharDone),
      .dataAvailableFlag(dataAvailableFlag), .readDataEnableN(readDataEnableN),
      .statusOutputEnableN(statusOutputEnableN), .rxDataBits(rxDataBits),
      .rxDataOe(rxDataOe), .statusBits(statusBits), .statusOe(statusOe));

   autr_station st (.txClock(txClock), .rxClock(rxClock), .serialOutLine(serialOutLine),
      .serialInLine(serialInLine));

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic bound(input int t, input int lim);
      if (t >= lim) begin
         num_errors++;
         $display("mismatch at %0t: wait ran out", $time);
         wrap_up();
      end
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      int t;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      t = 0;
      do begin
         @(posedge ref_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         t++;
      end while (!bvalid && t < 60);
      bound(t, 60);
      check(bresp, RESP_OKAY);
   endtask

   task automatic rd(input logic [5:0] a);
      int t;
      araddr <= a;
      arvalid <= 1'b1;
      t = 0;
      do begin
         @(posedge ref_clk);
         if (arready) arvalid <= 1'b0;
         t++;
      end while (!rvalid && t < 60);
      rv = rdata;
      rr = rresp;
      bound(t, 60);
   endtask

   task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
      rd(a);
      check(rv, exp);
      check(rr, RESP_OKAY);
   endtask

   // Transmit ticks from start edge until the done flag rises
   task automatic measure(output int k);
      int t;
      for (t = 0; t < 3000 && serialOutLine === 1'b1; t++) @(posedge ref_clk);
      bound(t, 3000);
      k = 0;
      for (t = 0; t < 300 && txCharDone !== 1'b1; t++) begin
         @(negedge txClock or posedge txCharDone);
         if (txCharDone !== 1'b1) k++;
      end
      bound(t, 300);
   endtask

   initial begin
      int n, ticks, ex, t;
      logic pe, sn, sp, pb;
      logic [7:0] d, m, da;
      repeat (4) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      check(serialOutLine, 1);
      check(txBufferEmpty, 1);
      check(txCharDone, 1);
      rdc({2'h0, REG_STATUS}, 32'h30);
      rdc({2'h0, REG_CTRL}, 32'h07);
      rd(6'h10);
      check(rr, RESP_SLVERR);
      // Every word length, both parity senses, all stop lengths, full duplex
      for (int w = 0; w < 4; w++) begin
         n = w + 5;
         pe = (w != 2);
         sn = w[0];
         sp = (w == 0 || w == 3);
         d = 8'h96 ^ 8'(w * 37);
         m = 8'hff >> (3 - w);
         pb = sn ? ^(d & m) : ~^(d & m);
         ex = (1 + n + pe) * 16 + (sp ? ((n == 5) ? 24 : 32) : 16);
         wr({2'h0, REG_CTRL}, {27'h0, sp, sn, ~pe, w[1:0]});
         fork
            st.grab(n, pe);
            st.send(d, n, pe, pb);
            measure(ticks);
            wr({2'h0, REG_TXDATA}, {24'h0, d});
         join
         check(st.gotData, d & m);
         if (pe) check(st.gotPar, pb);
         check(st.gotStop, 1);
         check(ticks >= ex - 1 && ticks <= ex + 1, 1);
         check(txCharDone, 1);
         rdc({2'h0, REG_RXDATA}, {24'h0, d & m});
         rdc({2'h0, REG_STATUS}, 32'h31);
         wr({2'h0, REG_STATUS}, 32'h1);
      end
      // Second character queued while the first is on the line
      wr({2'h0, REG_CTRL}, 32'h07);
      fork
         begin
            st.grab(8, 1'b0);
            da = st.gotData;
            st.grab(8, 1'b0);
         end
         begin
            wr({2'h0, REG_TXDATA}, 32'hc3);
            for (t = 0; t < 8 && serialOutLine === 1'b1; t++) @(posedge ref_clk);
            check(t < 8, 1);
            wr({2'h0, REG_TXDATA}, 32'h4e);
            check(txBufferEmpty, 0);
            check(txCharDone, 0);
         end
      join
      check(da, 8'hc3);
      check(st.gotData, 8'h4e);
      check(txBufferEmpty, 1);
      // Parity error, then overrun, 8 bits even parity
      wr({2'h0, REG_CTRL}, 32'h0b);
      st.send(8'h3c, 8, 1'b1, 1'b1);
      rdc({2'h0, REG_STATUS}, 32'h35);
      st.send(8'h5a, 8, 1'b1, 1'b0);
      rdc({2'h0, REG_STATUS}, 32'h33);
      check(dataAvailableFlag, 1);
      rdc({2'h0, REG_RXDATA}, 32'h5a);
      wr({2'h0, REG_STATUS}, 32'h1);
      check(dataAvailableFlag, 0);
      st.glitch();
      rd({2'h0, REG_STATUS});
      check(rv[ST_AVAIL], 0);
      st.send(8'h81, 8, 1'b1, 1'b0);
      rdc({2'h0, REG_STATUS}, 32'h31);
      rdc({2'h0, REG_RXDATA}, 32'h81);
      // Output enables for data and status pins
      readDataEnableN <= 1'b0;
      statusOutputEnableN <= 1'b0;
      repeat (2) @(posedge ref_clk);
      check(rxDataOe, 1);
      check(statusOe, 1);
      check(rxDataBits, 8'h81);
      check(statusBits, 6'h31);
      readDataEnableN <= 1'b1;
      statusOutputEnableN <= 1'b1;
      repeat (2) @(posedge ref_clk);
      check(rxDataOe, 0);
      check(statusOe, 0);
      wrap_up();
   end
endmodule
